// ===== shared/ee_consts.svh
// Offsets, field positions, reset values and timing for the EEPROM command logic
`ifndef EE_CONSTS_SVH
`define EE_CONSTS_SVH
`define CLK_MHZ 25
`define PROG_TIME_US 3000
`define SEL_LOW_NS 250
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_PEEK_ADDR 8'h08
`define REG_PEEK_DATA 8'h0C
`define CTRL_STANDBY_BIT 0
`define CTRL_RESET 1'b0
`define ST_UNLOCK_BIT 0
`define ST_BUSY_BIT 1
`define ST_ORG_BIT 2
`define ST_STATE_LSB 4
`define ADDR_BITS_X8 5'h07
`define ADDR_BITS_X16 5'h06
`define DATA_BITS_X8 5'h08
`define DATA_BITS_X16 5'h10
`define PIN_SEL 0
`define PIN_SCK 1
`define PIN_DIN 2
`define PIN_ORG 3
`endif

// ===== shared/ee_link_if.sv
// Synchronised serial pin events between pin front end and decoder
`timescale 1ns/1ps
`default_nettype none
interface ee_link_if;
  logic sel;
  logic sel_rise;
  logic sck_rise;
  logic din;
  logic org16;
  modport front (output sel, output sel_rise, output sck_rise, output din, output org16);
  modport core (input sel, input sel_rise, input sck_rise, input din, input org16);
endinterface
`default_nettype wire

// ===== shared/ee_pkg.sv
// Types for the EEPROM command logic
package ee_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_OPC = 3'b001,
    S_ADDR = 3'b010,
    S_DATA = 3'b011,
    S_READ = 3'b100,
    S_DONE = 3'b101
  } state_t;
  typedef enum logic [1:0] {
    OPC_MISC = 2'b00,
    OPC_WRITE = 2'b01,
    OPC_READ = 2'b10,
    OPC_ERASE = 2'b11
  } opc_t;
  typedef enum logic [1:0] {
    SUB_LOCK = 2'b00,
    SUB_BULK_PROG = 2'b01,
    SUB_BULK_CLR = 2'b10,
    SUB_UNLOCK = 2'b11
  } sub_t;
endpackage

// ===== tb/eeprom_host.sv
// Host model driving select, serial clock and serial data
`timescale 1ns/1ps
`default_nettype none
module eeprom_host (
  input wire logic hclk,
  input wire logic serial_out,
  output logic select_line,
  output logic serial_clock_in,
  output logic serial_in
);
  initial begin
    select_line = 1'b0;
    serial_clock_in = 1'b0;
    serial_in = 1'b0;
  end
  // Select rise opens a frame
  task automatic sel_on();
    @(posedge hclk);
    select_line <= 1'b1;
  endtask
  // Select low, clock parked low between frames
  task automatic sel_off(input int lo);
    @(posedge hclk);
    select_line <= 1'b0;
    serial_clock_in <= 1'b0;
    repeat (lo) @(posedge hclk);
  endtask
  // One 320 ns bit: data on low half, output sampled, then rise
  task automatic pulse(input logic b, output logic so);
    @(posedge hclk);
    serial_clock_in <= 1'b0;
    serial_in <= b;
    repeat (3) @(posedge hclk);
    so = serial_out;
    @(posedge hclk);
    serial_clock_in <= 1'b1;
    repeat (3) @(posedge hclk);
  endtask
  // Full field clocked out MSB first, don't-care bits included
  task automatic send(input logic [31:0] bits, input int n);
    logic so;
    for (int i = n - 1; i >= 0; i--) begin
      pulse(bits[i], so);
    end
  endtask
  // Collect n output bits, one per clock
  task automatic recv(input int n, output logic [31:0] v);
    logic so;
    v = 32'h0;
    for (int i = 0; i < n; i++) begin
      pulse(1'b0, so);
      v = {v[30:0], so};
    end
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Testbench for the serial EEPROM command logic
`timescale 1ns/1ps
`default_nettype none
`include "ee_consts.svh"
module tb_top;
  localparam int PCYC = 200;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic word_width_pin = 1'b1;
  logic hready;
  logic hreadyout;
  logic [31:0] hrdata;
  logic serial_out;
  logic serial_out_oe;
  logic select_line;
  logic serial_clock_in;
  logic serial_in;
  logic so_bus;
  logic hresp;
  logic [31:0] rv;
  int err_total = 0;
  int comparisons = 0;
  assign hready = hreadyout;
  // Released data line shows the inverse of serial_out
  assign so_bus = serial_out_oe ? serial_out : ~serial_out;
  always #20 hclk = ~hclk;
  three_wire_eeprom_command_logic #(.PROG_CYC(PCYC), .WORDS(64))
    u_three_wire_eeprom_command_logic (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .select_line(select_line),
    .serial_clock_in(serial_clock_in), .serial_in(serial_in),
    .word_width_pin(word_width_pin), .serial_out(serial_out), .serial_out_oe(serial_out_oe)
  );
  eeprom_host host (
    .hclk(hclk), .serial_out(so_bus), .select_line(select_line),
    .serial_clock_in(serial_clock_in), .serial_in(serial_in)
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (err_total == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Single AHB word transfer
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb(1'b0, a, 32'h0, rv);
    check(rv & m, e);
  endtask
  task automatic cmd(input logic [31:0] bits, input int n);
    host.sel_on();
    host.send(bits, n);
    host.sel_off(10);
  endtask
  // Serial read: dummy zero ahead of data
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    int na;
    host.sel_on();
    na = word_width_pin ? 6 : 7;
    host.send((32'h6 << na) | {25'h0, a}, 3 + na);
    host.recv((word_width_pin ? 16 : 8) + 1, rv);
    host.sel_off(10);
    check(rv, {16'h0, e});
  endtask
  // Programming command, then busy and ready on the pin
  task automatic prog(input logic [31:0] bits, input int n);
    int k;
    k = 0;
    cmd(bits, n);
    host.sel_on();
    repeat (8) @(posedge hclk);
    check({30'h0, serial_out_oe, serial_out}, 32'h2);
    while (serial_out !== 1'b1 && k < PCYC + 50) begin
      @(posedge hclk);
      k++;
    end
    check({30'h0, serial_out_oe, serial_out}, 32'h3);
    check({31'h0, k > PCYC - 60 && k <= PCYC}, 32'h1);
    host.sel_off(10);
  endtask
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(`REG_STATUS, 32'h3, 32'h0);
    rdchk(`REG_CTRL, 32'hFFFFFFFF, 32'h0);
    rdchk(8'h10, 32'hFFFFFFFF, 32'h0);
    cmd(32'h130, 9);
    rdchk(`REG_STATUS, 32'h1, 32'h0);
    repeat (20) @(posedge hclk);
    ahb(1'b1, `REG_CTRL, 32'h1, rv);
    rdchk(`REG_CTRL, 32'hFFFFFFFF, 32'h1);
    cmd({7'h0, 3'b101, 6'd5, 16'h1234}, 25);
    rdchk(`REG_STATUS, 32'h2, 32'h0);
    cmd(32'h130, 12);
    rdchk(`REG_STATUS, 32'h1, 32'h1);
    prog({7'h0, 3'b100, 6'h10, 16'h3C3C}, 25);
    rd(7'd0, 16'h3C3C);
    rd(7'd63, 16'h3C3C);
    prog({3'b111, 6'd5}, 9);
    rd(7'd5, 16'hFFFF);
    rd(7'd6, 16'h3C3C);
    prog({7'h0, 3'b101, 6'd5, 16'hA55A}, 25);
    rd(7'd5, 16'hA55A);
    rdchk(`REG_STATUS, 32'h77, 32'h5);
    word_width_pin <= 1'b0;
    rd(7'd11, 16'h00A5);
    rd(7'd10, 16'h005A);
    prog({7'h0, 3'b101, 7'd10, 8'hC3}, 18);
    rd(7'd10, 16'h00C3);
    rdchk(`REG_STATUS, 32'h4, 32'h0);
    prog({3'b111, 7'd11}, 10);
    rd(7'd11, 16'h00FF);
    word_width_pin <= 1'b1;
    cmd(32'h6, 3);
    rd(7'd5, 16'hFFC3);
    host.sel_on();
    host.send({7'h0, 3'b101, 6'd6, 16'h0F0F}, 25);
    host.sel_off(PCYC + 40);
    host.sel_on();
    repeat (8) @(posedge hclk);
    check({31'h0, serial_out_oe}, 32'h0);
    host.sel_off(10);
    rd(7'd6, 16'h0F0F);
    prog({3'b100, 6'h20}, 9);
    ahb(1'b1, `REG_PEEK_ADDR, 32'h2A, rv);
    rdchk(`REG_PEEK_DATA, 32'hFFFF, 32'hFFFF);
    cmd({3'b100, 6'h00}, 9);
    rdchk(`REG_STATUS, 32'h1, 32'h0);
    cmd({7'h0, 3'b101, 6'd5, 16'h0000}, 25);
    rdchk(`REG_STATUS, 32'h2, 32'h0);
    rd(7'd5, 16'hFFFF);
    report_and_stop();
  end
  initial begin
    repeat (40000) @(posedge hclk);
    err_total++;
    report_and_stop();
  end
endmodule
`default_nettype wire

// ===== verilog/serial_front.sv
// Pin synchronisers and edge detection for the serial link
`timescale 1ns/1ps
`default_nettype none
`include "ee_consts.svh"
module serial_front (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic select_line,
  input wire logic serial_clock_in,
  input wire logic serial_in,
  input wire logic word_width_pin,
  ee_link_if.front lnk
);
  import ee_pkg::*;
  logic [3:0] m1_q;
  logic [3:0] m1_d;
  logic [3:0] m2_q;
  logic [3:0] m2_d;
  logic [3:0] p_q;
  logic [3:0] p_d;

  always_comb begin
    m1_d[`PIN_SEL] = select_line;
    m1_d[`PIN_SCK] = serial_clock_in;
    m1_d[`PIN_DIN] = serial_in;
    m1_d[`PIN_ORG] = word_width_pin;
    m2_d = m1_q;
    p_d = m2_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      m1_q <= 4'h0;
      m2_q <= 4'h0;
      p_q <= 4'h0;
    end else begin
      m1_q <= m1_d;
      m2_q <= m2_d;
      p_q <= p_d;
    end
  end

  assign lnk.sel = m2_q[`PIN_SEL];
  assign lnk.sel_rise = m2_q[`PIN_SEL] & ~p_q[`PIN_SEL];
  assign lnk.sck_rise = m2_q[`PIN_SCK] & ~p_q[`PIN_SCK];
  assign lnk.din = m2_q[`PIN_DIN];
  assign lnk.org16 = m2_q[`PIN_ORG];
endmodule
`default_nettype wire

// ===== verilog/three_wire_eeprom_command_logic.sv
// Command decoder, sequencer, array and register slave of the serial EEPROM
`timescale 1ns/1ps
`default_nettype none
`include "ee_consts.svh"
module three_wire_eeprom_command_logic #(
  parameter int unsigned PROG_CYC = `PROG_TIME_US * `CLK_MHZ,
  parameter int unsigned WORDS = 64
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic select_line,
  input wire logic serial_clock_in,
  input wire logic serial_in,
  input wire logic word_width_pin,
  output logic serial_out,
  output logic serial_out_oe
);
  import ee_pkg::*;
  localparam int unsigned SEL_LOW_CYC = (`SEL_LOW_NS * `CLK_MHZ + 999) / 1000;

  state_t state_q, state_d;
  opc_t opc_q, opc_d;
  sub_t sub;
  logic [4:0] cnt_q, cnt_d;
  logic [6:0] addr_q, addr_d, full_addr, cur_addr;
  logic [15:0] data_q, data_d, full_data, sh_q, sh_d, rd_word, mask_b;
  logic [5:0] word_idx, peek_q, peek_d;
  logic dout_q, dout_d, oe_q, oe_d, unlock_q, unlock_d, org_q, org_d;
  logic stat_q, stat_d, busy_q, busy_d, ctrl_q, ctrl_d, wr_q, wr_d, acc;
  logic [31:0] tmr_q, tmr_d, hrdata_q, hrdata_d;
  logic [15:0] low_q, low_d;
  logic [7:0] wa_q, wa_d;
  logic low_ok, prog_req, prog_go, read_go, unlock_go, lock_go, erase_go, write_go;
  logic p_all;
  logic [15:0] p_mask, p_wdata;
  logic [15:0] mem_q [0:WORDS-1];

  ee_link_if lnk ();

  serial_front u_front (
    .hclk(hclk),
    .hresetn(hresetn),
    .select_line(select_line),
    .serial_clock_in(serial_clock_in),
    .serial_in(serial_in),
    .word_width_pin(word_width_pin),
    .lnk(lnk)
  );

  function automatic logic [4:0] addr_len(input logic x16);
    addr_len = x16 ? `ADDR_BITS_X16 : `ADDR_BITS_X8;
  endfunction

  function automatic logic [4:0] data_len(input logic x16);
    data_len = x16 ? `DATA_BITS_X16 : `DATA_BITS_X8;
  endfunction

  // Address and data decode shared by all commands
  always_comb begin
    full_addr = {addr_q[5:0], lnk.din};
    full_data = {data_q[14:0], lnk.din};
    cur_addr = (state_q == S_ADDR) ? full_addr : addr_q;
    sub = org_q ? sub_t'(cur_addr[5:4]) : sub_t'(cur_addr[6:5]);
    word_idx = org_q ? cur_addr[5:0] : cur_addr[6:1];
    mask_b = cur_addr[0] ? 16'hFF00 : 16'h00FF;
    rd_word = mem_q[word_idx];
    low_ok = low_q >= 16'(SEL_LOW_CYC);
  end

  // Instruction sequencer
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    opc_d = opc_q;
    addr_d = addr_q;
    data_d = data_q;
    sh_d = sh_q;
    dout_d = dout_q;
    oe_d = oe_q;
    unlock_d = unlock_q;
    org_d = org_q;
    stat_d = stat_q;
    prog_req = 1'b0;
    read_go = 1'b0;
    unlock_go = 1'b0;
    lock_go = 1'b0;
    erase_go = 1'b0;
    write_go = 1'b0;
    p_all = 1'b0;
    p_mask = 16'hFFFF;
    p_wdata = 16'hFFFF;
    if (!lnk.sel || !ctrl_q) begin
      state_d = S_IDLE;
      oe_d = 1'b0;
      stat_d = 1'b0;
    end else if (lnk.sel_rise) begin
      stat_d = busy_q && low_ok;
      oe_d = busy_q && low_ok;
      dout_d = !busy_q;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (stat_q) begin
            dout_d = !busy_q;
          end
          if (lnk.sck_rise && lnk.din && !busy_q) begin
            state_d = S_OPC;
            cnt_d = 5'h00;
            org_d = lnk.org16;
            stat_d = 1'b0;
            oe_d = 1'b0;
          end
        end
        S_OPC: begin
          if (lnk.sck_rise) begin
            opc_d = opc_t'({opc_q[0], lnk.din});
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == 5'h01) begin
              state_d = S_ADDR;
              cnt_d = 5'h00;
            end
          end
        end
        S_ADDR: begin
          if (lnk.sck_rise) begin
            addr_d = full_addr;
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == addr_len(org_q) - 5'h01) begin
              cnt_d = 5'h00;
              state_d = S_DONE;
              unique case (opc_q)
                OPC_READ: begin
                  read_go = 1'b1;
                  state_d = S_READ;
                  dout_d = 1'b0;
                  oe_d = 1'b1;
                  if (org_q) begin
                    sh_d = rd_word;
                  end else begin
                    sh_d = {(cur_addr[0] ? rd_word[15:8] : rd_word[7:0]), 8'h00};
                  end
                end
                OPC_ERASE: begin
                  erase_go = 1'b1;
                  prog_req = 1'b1;
                  p_mask = org_q ? 16'hFFFF : mask_b;
                end
                OPC_WRITE: begin
                  state_d = S_DATA;
                end
                OPC_MISC: begin
                  unique case (sub)
                    SUB_UNLOCK: begin
                      unlock_d = 1'b1;
                      unlock_go = 1'b1;
                    end
                    SUB_LOCK: begin
                      unlock_d = 1'b0;
                      lock_go = 1'b1;
                    end
                    SUB_BULK_CLR: begin
                      erase_go = 1'b1;
                      prog_req = 1'b1;
                      p_all = 1'b1;
                    end
                    SUB_BULK_PROG: begin
                      state_d = S_DATA;
                    end
                  endcase
                end
              endcase
            end
          end
        end
        S_DATA: begin
          if (lnk.sck_rise) begin
            data_d = full_data;
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == data_len(org_q) - 5'h01) begin
              state_d = S_DONE;
              write_go = 1'b1;
              prog_req = 1'b1;
              p_all = (opc_q == OPC_MISC);
              p_wdata = org_q ? full_data : {full_data[7:0], full_data[7:0]};
              p_mask = (org_q || p_all) ? 16'hFFFF : mask_b;
            end
          end
        end
        S_READ: begin
          if (lnk.sck_rise) begin
            dout_d = sh_q[15];
            sh_d = {sh_q[14:0], 1'b0};
          end
        end
        S_DONE: begin
          state_d = S_DONE;
        end
        default: begin
          state_d = S_IDLE;
        end
      endcase
    end
  end

  assign prog_go = prog_req && unlock_q;

  // Self-timed programming cycle and select low timer
  always_comb begin
    busy_d = busy_q;
    tmr_d = tmr_q;
    if (busy_q) begin
      if (tmr_q == 32'h0) begin
        busy_d = 1'b0;
      end else begin
        tmr_d = tmr_q - 32'h1;
      end
    end
    if (prog_go) begin
      busy_d = 1'b1;
      tmr_d = PROG_CYC - 1;
    end
    low_d = lnk.sel ? 16'h0 : (low_ok ? low_q : low_q + 16'h1);
  end

  // Register slave
  always_comb begin
    acc = hsel && htrans[1] && hready;
    wr_d = acc && hwrite;
    wa_d = acc ? haddr[7:0] : wa_q;
    ctrl_d = ctrl_q;
    peek_d = peek_q;
    hrdata_d = hrdata_q;
    if (wr_q && wa_q == `REG_CTRL) begin
      ctrl_d = hwdata[`CTRL_STANDBY_BIT];
    end
    if (wr_q && wa_q == `REG_PEEK_ADDR) begin
      peek_d = hwdata[5:0];
    end
    if (acc && !hwrite) begin
      hrdata_d = 32'h0;
      case (haddr[7:0])
        `REG_CTRL: hrdata_d[`CTRL_STANDBY_BIT] = ctrl_q;
        `REG_STATUS: begin
          hrdata_d[`ST_UNLOCK_BIT] = unlock_q;
          hrdata_d[`ST_BUSY_BIT] = busy_q;
          hrdata_d[`ST_ORG_BIT] = org_q;
          hrdata_d[`ST_STATE_LSB +: 3] = state_q;
        end
        `REG_PEEK_ADDR: hrdata_d[5:0] = peek_q;
        `REG_PEEK_DATA: hrdata_d[15:0] = mem_q[peek_q];
        default: hrdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= S_IDLE;
      opc_q <= OPC_MISC;
      cnt_q <= 5'h00;
      addr_q <= 7'h00;
      data_q <= 16'h0000;
      sh_q <= 16'h0000;
      dout_q <= 1'b0;
      oe_q <= 1'b0;
      unlock_q <= 1'b0;
      org_q <= 1'b0;
      stat_q <= 1'b0;
      busy_q <= 1'b0;
      tmr_q <= 32'h0;
      low_q <= 16'h0;
      ctrl_q <= `CTRL_RESET;
      peek_q <= 6'h00;
      wr_q <= 1'b0;
      wa_q <= 8'h00;
      hrdata_q <= 32'h0;
    end else begin
      state_q <= state_d;
      opc_q <= opc_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      data_q <= data_d;
      sh_q <= sh_d;
      dout_q <= dout_d;
      oe_q <= oe_d;
      unlock_q <= unlock_d;
      org_q <= org_d;
      stat_q <= stat_d;
      busy_q <= busy_d;
      tmr_q <= tmr_d;
      low_q <= low_d;
      ctrl_q <= ctrl_d;
      peek_q <= peek_d;
      wr_q <= wr_d;
      wa_q <= wa_d;
      hrdata_q <= hrdata_d;
    end
  end

  // Array update, single location or all
  always_ff @(posedge hclk) begin
    if (prog_go) begin
      for (int i = 0; i < WORDS; i++) begin
        if (p_all || word_idx == 6'(i)) begin
          mem_q[i] <= (mem_q[i] & ~p_mask) | (p_wdata & p_mask);
        end
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign serial_out = dout_q;
  assign serial_out_oe = oe_q;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_read_go;
    read_go;
  endsequence
  sequence s_dummy_out;
    (dout_q == 1'b0) && oe_q && (state_q == S_READ);
  endsequence

  read_dummy_a: assert property (s_read_go |=> s_dummy_out)
    else $error("read did not start with dummy zero");
  read_edge_a: assert property ((state_q == S_READ) && $past(state_q == S_READ)
    && $changed(dout_q) |-> $past(lnk.sck_rise))
    else $error("read data changed without clock rise");
  unlock_set_a: assert property (unlock_go |=> unlock_q)
    else $error("unlock did not set latch");
  latch_hold_a: assert property ($fell(unlock_q) |-> $past(lock_go))
    else $error("latch cleared without lock command");
  locked_refuse_a: assert property (prog_req && !unlock_q |=> !busy_q)
    else $error("program started while locked");
  erase_start_a: assert property (erase_go && unlock_q |=> busy_q && tmr_q == PROG_CYC - 1)
    else $error("erase cycle did not start at decode");
  write_start_a: assert property (write_go && unlock_q |=> busy_q ##1 busy_q)
    else $error("write cycle did not start");
  bulk_clear_a: assert property (erase_go && p_all && unlock_q |=> mem_q[0] == 16'hFFFF
    && mem_q[WORDS-1] == 16'hFFFF)
    else $error("bulk clear left a zero");
  deselect_idle_a: assert property (!lnk.sel |=> state_q == S_IDLE && !oe_q)
    else $error("decoder not idle while deselected");
  standby_gate_a: assert property (!ctrl_q |=> state_q == S_IDLE)
    else $error("command accepted before standby");
  status_busy_a: assert property (stat_q && busy_q && $past(stat_q) |-> oe_q && !dout_q)
    else $error("status not busy during cycle");
  status_late_a: assert property (lnk.sel_rise && !busy_q |=> !stat_q && !oe_q)
    else $error("status shown after cycle end");
endmodule
`default_nettype wire
